// ==== acmd_pkg.sv ====
// Constants, types and register map of the access code memory decoder.
// Function
// - Map each 12-bit fetch to one store.
// - Reach 9k of stores via access code.
// - Six user access codes, 0 through 5.
// - Low 1k: RAM, on-chip ROM or monitor.
// - Above 1k: port, expansion, or monitor calls.
// - Monitor mode: upper fetches go to monitor ROM, upper data is system I/O.
// - Upgrade fitted: twelve access codes allowed.
// - 1k writable program store replaces on-chip.
// - Monitor firmware mapped only when selected.
// - 256-byte user data memory, 0 to FF.
// - Separate 256-byte monitor scratchpad store.
// - Code decides data space above 3FF.
// - Data page from port 2 low nibble.
// - Reset enters monitor mode.
// - Addresses 3F0 to 3FF kept for reentry.
package acmd_pkg;

   // Register byte offsets on APB.
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] MEM_ADDR_OFS = 8'h08;
   localparam logic [7:0] PRAM_OFS     = 8'h0C;
   localparam logic [7:0] UDATA_OFS    = 8'h10;
   localparam logic [7:0] SCRATCH_OFS  = 8'h14;

   // Control field positions and reset values.
   localparam int CTRL_CODE_LSB  = 0;
   localparam int CTRL_MON_BIT   = 4;
   localparam int CTRL_UPG_BIT   = 5;
   localparam logic [3:0] CODE_RST = 4'h0;
   localparam logic       MON_RST  = 1'b1;
   localparam logic       UPG_RST  = 1'b0;

   // Access code counts and address boundaries.
   localparam logic [3:0]  CODES_BASE    = 4'h6;
   localparam logic [3:0]  CODES_UPGRADE = 4'hC;
   localparam logic [11:0] LOW_TOP       = 12'h3FF;
   localparam logic [11:0] REENTRY_BASE  = 12'h3F0;
   localparam logic [3:0]  DATA_PAGE_HI  = 4'h4;

   // Physical stores that may answer a cycle.
   typedef enum logic [2:0] {
      ST_NONE, ST_ONCHIP, ST_PRAM, ST_MONROM,
      ST_EXPAN, ST_SYSIO, ST_UDATA, ST_SCRATCH
   } acmd_store_e;

   // Current selection of program and data store.
   typedef struct packed {
      acmd_store_e prog;
      acmd_store_e data;
   } acmd_sel_s;

endpackage

// ==== acmd_decoder.sv ====
// Access code memory decoder with APB register file and in-box stores.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
module acmd_decoder (
   input  wire logic        core_clk,     // System clock, 200 MHz.
   input  wire logic        rstn,         // Async reset, active low.
   input  wire logic        psel,         // APB select.
   input  wire logic        penable,      // APB enable.
   input  wire logic        pwrite,       // APB direction.
   input  wire logic [7:0]  paddr,        // APB byte address.
   input  wire logic [31:0] pwdata,       // APB write data.
   output logic      [31:0] prdata,       // APB read data.
   output logic             pready,       // APB ready.
   output logic             pslverr,      // APB error, unmapped.
   input  wire logic [11:0] prog_addr,    // Processor program address.
   input  wire logic        fetch_n,      // Program fetch strobe, low.
   input  wire logic        rd_n,         // Data read strobe, low.
   input  wire logic        wr_n,         // Data write strobe, low.
   input  wire logic [7:0]  bus_in,       // Bus port level in.
   input  wire logic [3:0]  port2_lo,     // Port 2 low nibble, page.
   output logic      [7:0]  bus_out,      // Bus port drive value.
   output logic             bus_oe,       // Bus port drive enable.
   output acmd_pkg::acmd_sel_s store_sel  // Store now answering.
);

   localparam int PRAM_DEPTH = 1024;
   localparam int DMEM_DEPTH = 256;

   logic [3:0]  code;
   logic        mon_mode;
   logic        upg;
   logic [9:0]  mem_addr;
   logic        reentry_hit;
   logic [7:0]  pram [PRAM_DEPTH];
   logic [7:0]  udata [DMEM_DEPTH];
   logic [7:0]  scratch [DMEM_DEPTH];

   // Two-flop synchronisers for all processor pins.
   logic [11:0] addr_s1, addr_s2;
   logic [7:0]  bus_s1, bus_s2;
   logic [3:0]  pg_s1, pg_s2;
   logic [2:0]  str_s1, str_s2;
   logic        wr_d;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage is ever read.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         addr_s1 <= 12'h000;
         addr_s2 <= 12'h000;
         bus_s1  <= 8'h00;
         bus_s2  <= 8'h00;
         pg_s1   <= 4'h0;
         pg_s2   <= 4'h0;
         str_s1  <= 3'h7;
         str_s2  <= 3'h7;
      end else begin
         addr_s1 <= prog_addr;
         addr_s2 <= addr_s1;
         bus_s1  <= bus_in;
         bus_s2  <= bus_s1;
         pg_s1   <= port2_lo;
         pg_s2   <= pg_s1;
         str_s1  <= {fetch_n, rd_n, wr_n};
         str_s2  <= str_s1;
      end
   end

   wire fetch  = !str_s2[2];
   wire d_rd   = !str_s2[1];
   wire d_wr   = !str_s2[0];
   wire d_wr_r = d_wr && !wr_d;

   ////////////////////////////////////////////////////////////////////
   // Program store decode from address, code and monitor mode.
   function automatic acmd_pkg::acmd_store_e prog_dec(
      input logic [11:0] a, input logic [3:0] c, input logic mon);
      logic [3:0] base;
      base = (c >= acmd_pkg::CODES_BASE) ?
             4'(c - acmd_pkg::CODES_BASE) : c;
      if (a <= acmd_pkg::LOW_TOP) begin
         if (mon)
            prog_dec = acmd_pkg::ST_MONROM;
         else if (base < 4'h3)
            prog_dec = acmd_pkg::ST_PRAM;
         else
            prog_dec = acmd_pkg::ST_ONCHIP;
      end else if (mon) begin
         prog_dec = acmd_pkg::ST_MONROM;
      end else begin
         case (base)
            4'h1, 4'h4: prog_dec = acmd_pkg::ST_EXPAN;
            4'h2, 4'h5: prog_dec = acmd_pkg::ST_MONROM;
            default:    prog_dec = acmd_pkg::ST_NONE;
         endcase
      end
   endfunction

   // Data store decode from pointer page and access code.
   function automatic acmd_pkg::acmd_store_e data_dec(
      input logic [3:0] pg, input logic [3:0] c, input logic mon);
      logic [3:0] base;
      base = (c >= acmd_pkg::CODES_BASE) ?
             4'(c - acmd_pkg::CODES_BASE) : c;
      if (pg == 4'h0)
         data_dec = mon ? acmd_pkg::ST_SCRATCH
                        : acmd_pkg::ST_UDATA;
      else if (pg < acmd_pkg::DATA_PAGE_HI)
         data_dec = acmd_pkg::ST_NONE;
      else if (mon)
         data_dec = acmd_pkg::ST_SYSIO;
      else begin
         case (base)
            4'h1, 4'h4: data_dec = acmd_pkg::ST_EXPAN;
            4'h2, 4'h5: data_dec = acmd_pkg::ST_SYSIO;
            default:    data_dec = acmd_pkg::ST_NONE;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // APB slave: two-cycle access, ready raised in the second cycle.
   wire apb_req = psel && penable && !pready;
   wire apb_wr  = psel && penable && pready && pwrite;
   wire mapped  = (paddr <= acmd_pkg::SCRATCH_OFS) && (paddr[1:0] == 2'b00);
   wire [3:0] wcode = pwdata[acmd_pkg::CTRL_CODE_LSB +: 4];
   wire [3:0] code_lim = upg ? acmd_pkg::CODES_UPGRADE
                             : acmd_pkg::CODES_BASE;

   // Ready, error and read data are all registered.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apb_req;
         pslverr <= apb_req && !mapped;
         if (apb_req && !pwrite) begin
            case (paddr)
               acmd_pkg::CTRL_OFS:     prdata <= {26'h0, upg, mon_mode, code};
               acmd_pkg::STATUS_OFS:   prdata <= {25'h0, reentry_hit,
                                                  store_sel};
               acmd_pkg::MEM_ADDR_OFS: prdata <= {22'h0, mem_addr};
               acmd_pkg::PRAM_OFS:     prdata <= {24'h0, pram[mem_addr]};
               acmd_pkg::UDATA_OFS:    prdata <= {24'h0,
                                                  udata[mem_addr[7:0]]};
               acmd_pkg::SCRATCH_OFS:  prdata <= {24'h0,
                                                  scratch[mem_addr[7:0]]};
               default:                prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control register; monitor mode from reset, code out of range ignored.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         code     <= acmd_pkg::CODE_RST;
         mon_mode <= acmd_pkg::MON_RST;
         upg      <= acmd_pkg::UPG_RST;
      end else if (apb_wr && paddr == acmd_pkg::CTRL_OFS) begin
         if (wcode < code_lim)
            code <= wcode;
         mon_mode <= pwdata[acmd_pkg::CTRL_MON_BIT];
         upg      <= pwdata[acmd_pkg::CTRL_UPG_BIT];
      end
   end

   // Memory window pointer, bumped after each data port access.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         mem_addr <= 10'h000;
      else if (apb_wr && paddr == acmd_pkg::MEM_ADDR_OFS)
         mem_addr <= pwdata[9:0];
      else if (psel && penable && pready && mapped &&
               paddr >= acmd_pkg::PRAM_OFS)
         mem_addr <= 10'(mem_addr + 10'h001);
   end

   ////////////////////////////////////////////////////////////////////
   // In-box program RAM; only software loads it, the processor reads.
   always_ff @(posedge core_clk) begin
      if (apb_wr && paddr == acmd_pkg::PRAM_OFS)
         pram[mem_addr] <= pwdata[7:0];
   end

   // Data stores take bus writes from pointer moves or software.
   always_ff @(posedge core_clk) begin
      // The registered selection still shows the idle cycle on the first
      // synced write edge, so the decode is taken straight from the pins.
      if (d_wr_r && data_dec(pg_s2, code, mon_mode) == acmd_pkg::ST_UDATA)
         udata[addr_s2[7:0]] <= bus_s2;
      else if (apb_wr && paddr == acmd_pkg::UDATA_OFS)
         udata[mem_addr[7:0]] <= pwdata[7:0];
   end

   // Scratchpad is kept apart so user moves never touch it.
   always_ff @(posedge core_clk) begin
      if (d_wr_r && data_dec(pg_s2, code, mon_mode) == acmd_pkg::ST_SCRATCH)
         scratch[addr_s2[7:0]] <= bus_s2;
      else if (apb_wr && paddr == acmd_pkg::SCRATCH_OFS)
         scratch[mem_addr[7:0]] <= pwdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////
   // Registered store selection for the present cycle.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         store_sel.prog <= acmd_pkg::ST_NONE;
         store_sel.data <= acmd_pkg::ST_NONE;
         wr_d           <= 1'b0;
      end else begin
         wr_d <= d_wr;
         store_sel.prog <= fetch ? prog_dec(addr_s2, code, mon_mode)
                                 : acmd_pkg::ST_NONE;
         store_sel.data <= (d_rd || d_wr) ?
                           data_dec(pg_s2, code, mon_mode)
                           : acmd_pkg::ST_NONE;
      end
   end

   // Sticky flag for a user fetch into the reentry area.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         reentry_hit <= 1'b0;
      else if (fetch && !mon_mode && addr_s2 >= acmd_pkg::REENTRY_BASE &&
               addr_s2 <= acmd_pkg::LOW_TOP)
         reentry_hit <= 1'b1;
      else if (apb_wr && paddr == acmd_pkg::STATUS_OFS)
         reentry_hit <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Bus drive: only in-box stores are driven here, one at a time, so
   // an external or on-chip store never meets a contending driver.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bus_out <= 8'h00;
         bus_oe  <= 1'b0;
      end else if (fetch && prog_dec(addr_s2, code, mon_mode) ==
                   acmd_pkg::ST_PRAM) begin
         bus_out <= pram[addr_s2[9:0]];
         bus_oe  <= 1'b1;
      end else if (d_rd && data_dec(pg_s2, code, mon_mode) ==
                   acmd_pkg::ST_UDATA) begin
         bus_out <= udata[addr_s2[7:0]];
         bus_oe  <= 1'b1;
      end else if (d_rd && data_dec(pg_s2, code, mon_mode) ==
                   acmd_pkg::ST_SCRATCH) begin
         bus_out <= scratch[addr_s2[7:0]];
         bus_oe  <= 1'b1;
      end else begin
         bus_out <= 8'h00;
         bus_oe  <= 1'b0;
      end
   end

endmodule

// ==== acmd_decoder_sva.sv ====
// Concurrent checks on the decoder's register bus and processor-side ports.
`timescale 1ns/100ps
module acmd_decoder_sva (
   input wire logic                core_clk,  // Clock.
   input wire logic                rstn,      // Async reset, active low.
   input wire logic                psel,      // APB select.
   input wire logic                penable,   // APB enable.
   input wire logic                pwrite,    // APB direction.
   input wire logic [7:0]          paddr,     // APB address.
   input wire logic                pready,    // APB ready.
   input wire logic [11:0]         prog_addr, // Fetch or pointer address.
   input wire logic                fetch_n,   // Fetch strobe, low.
   input wire logic                rd_n,      // Read strobe, low.
   input wire logic                wr_n,      // Write strobe, low.
   input wire logic [3:0]          port2_lo,  // Data page number.
   input wire logic                bus_oe,    // Bus drive enable.
   input wire acmd_pkg::acmd_sel_s store_sel  // Store selection.
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic ctl_seen;
   // Boot checks stop at the first control write, since it may leave monitor.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         ctl_seen <= 1'b0;
      else if (psel && penable && pwrite && paddr == acmd_pkg::CTRL_OFS)
         ctl_seen <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Strobes held four edges outlast the sync and decode latency.
   sequence s_fetch;
      (!fetch_n && $stable(prog_addr))[*4];
   endsequence
   sequence s_read;
      (!rd_n && $stable(port2_lo) && $stable(prog_addr))[*4];
   endsequence
   property p_apb_ready;
      psel && penable && !pready |=> pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("ready late");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready long");
   property p_low_store;
      s_fetch ##0 prog_addr <= acmd_pkg::LOW_TOP |-> store_sel.prog inside
         {acmd_pkg::ST_PRAM, acmd_pkg::ST_ONCHIP, acmd_pkg::ST_MONROM};
   endproperty
   a_low_store: assert property (p_low_store) else $error("low store");
   property p_high_store;
      s_fetch ##0 prog_addr > acmd_pkg::LOW_TOP |-> !(store_sel.prog inside
         {acmd_pkg::ST_PRAM, acmd_pkg::ST_ONCHIP});
   endproperty
   a_high_store: assert property (p_high_store) else $error("high store");
   property p_boot_mon;
      s_fetch ##0 !ctl_seen |-> store_sel.prog == acmd_pkg::ST_MONROM;
   endproperty
   a_boot_mon: assert property (p_boot_mon) else $error("boot store");
   property p_idle;
      (fetch_n && rd_n && wr_n)[*4] |-> !bus_oe &&
         store_sel == {acmd_pkg::ST_NONE, acmd_pkg::ST_NONE};
   endproperty
   a_idle: assert property (p_idle) else $error("idle drive");
   property p_page_none;
      s_read ##0 port2_lo inside {[1:3]} |->
         store_sel.data == acmd_pkg::ST_NONE;
   endproperty
   a_page_none: assert property (p_page_none) else $error("page 1-3");
   property p_page_zero;
      s_read ##0 port2_lo == 4'h0 |-> store_sel.data inside
         {acmd_pkg::ST_UDATA, acmd_pkg::ST_SCRATCH};
   endproperty
   a_page_zero: assert property (p_page_zero) else $error("page 0");
endmodule
bind acmd_decoder acmd_decoder_sva acmd_decoder_sva_inst (
   .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .prog_addr(prog_addr),
   .fetch_n(fetch_n), .rd_n(rd_n), .wr_n(wr_n), .port2_lo(port2_lo),
   .bus_oe(bus_oe), .store_sel(store_sel));

// ==== acmd_proc_model.sv ====
// Behavioural execution processor making fetches and external data moves.
`timescale 1ns/100ps
module acmd_proc_model (
   input  wire logic        core_clk,  // Clock.
   input  wire logic [7:0]  bus_out,   // Decoder bus drive value.
   input  wire logic        bus_oe,    // Decoder bus drive enable.
   output logic      [11:0] prog_addr, // Fetch or pointer address.
   output logic             fetch_n,   // Fetch strobe, low.
   output logic             rd_n,      // Data read strobe, low.
   output logic             wr_n,      // Data write strobe, low.
   output logic      [3:0]  port2_lo,  // Data page number.
   output logic      [7:0]  bus_in     // Resolved bus level.
);
   logic [7:0] wdat = 8'h00;
   // A released bus shows the inverse of the data byte given to the last cycle.
   assign bus_in = bus_oe ? bus_out : (!wr_n ? wdat : ~wdat);
   initial begin
      prog_addr = 12'h000;
      port2_lo = 4'h0;
      {fetch_n, rd_n, wr_n} = 3'h7;
   end
   // Kind 0 fetch, 1 read, 2 write; held four edges, outlasting the sync latency.
   task automatic cyc(input int k, input logic [11:0] a,
                      input logic [3:0] pg, input logic [7:0] d);
      @(posedge core_clk);
      prog_addr <= a;
      port2_lo <= pg;
      wdat <= d;
      fetch_n <= (k != 0);
      rd_n <= (k != 1);
      wr_n <= (k != 2);
      repeat (4) @(posedge core_clk);
   endtask
   // All strobes released and left to settle.
   task automatic idle();
      @(posedge core_clk);
      {fetch_n, rd_n, wr_n} <= 3'h7;
      repeat (4) @(posedge core_clk);
   endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench: APB register tasks and processor cycles.
`timescale 1ns/100ps
module tb_top;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, se;
   logic [7:0] paddr = 8'h00, bus_in, bus_out;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [11:0] prog_addr;
   logic fetch_n, rd_n, wr_n, bus_oe;
   logic [3:0] port2_lo;
   acmd_pkg::acmd_sel_s store_sel;
   acmd_pkg::acmd_store_e hi_tab [3] = '{acmd_pkg::ST_NONE,
      acmd_pkg::ST_EXPAN, acmd_pkg::ST_MONROM};
   acmd_pkg::acmd_store_e dt_tab [3] = '{acmd_pkg::ST_NONE,
      acmd_pkg::ST_EXPAN, acmd_pkg::ST_SYSIO};
   int err_total = 0;
   int tests_run = 0;
   always #2.5 core_clk = ~core_clk;
   acmd_decoder acmd_decoder_inst (.core_clk(core_clk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_addr(prog_addr), .fetch_n(fetch_n), .rd_n(rd_n), .wr_n(wr_n),
      .bus_in(bus_in), .port2_lo(port2_lo), .bus_out(bus_out),
      .bus_oe(bus_oe), .store_sel(store_sel));
   acmd_proc_model proc (.core_clk(core_clk), .bus_out(bus_out),
      .bus_oe(bus_oe), .prog_addr(prog_addr), .fetch_n(fetch_n),
      .rd_n(rd_n), .wr_n(wr_n), .port2_lo(port2_lo), .bus_in(bus_in));
   ////////////////////////////////////////////////////////////////////////////
   // Every comparison is counted; a mismatch is printed at once.
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // One APB transfer; waits for ready however long the slave takes.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic end_of_test();
      if (err_total == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // A hang is cut short well past the expected run length.
   initial begin
      #100000;
      err_total++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      apb(0, acmd_pkg::CTRL_OFS, 0);
      chk("ctrl", {26'h0, acmd_pkg::UPG_RST, acmd_pkg::MON_RST,
                   acmd_pkg::CODE_RST}, rd);
      proc.cyc(0, 12'h100, 4'h0, 8'h00);
      chk("boot", acmd_pkg::ST_MONROM, store_sel.prog);
      proc.cyc(0, 12'hC00, 4'h0, 8'h00);
      chk("mon_hi", acmd_pkg::ST_MONROM, store_sel.prog);
      proc.cyc(1, 12'h005, 4'h4, 8'h00);
      chk("mon_io", acmd_pkg::ST_SYSIO, store_sel.data);
      proc.cyc(1, 12'h005, 4'h0, 8'h00);
      chk("scratch", acmd_pkg::ST_SCRATCH, store_sel.data);
      proc.idle();
      apb(1, acmd_pkg::MEM_ADDR_OFS, 32'h3F0);
      apb(1, acmd_pkg::PRAM_OFS, 32'hA5);
      apb(1, acmd_pkg::MEM_ADDR_OFS, 32'h005);
      apb(1, acmd_pkg::UDATA_OFS, 32'h3C);
      apb(1, acmd_pkg::SCRATCH_OFS, 32'h77);
      apb(1, 8'h18, 32'hFF);
      chk("slverr", 1, se);
      apb(0, 8'h02, 0);
      chk("unmap_err", 1, se);
      chk("unmap", 32'h0, rd);
      // Each user code sets its own low, high and paged data stores.
      for (int c = 0; c < 6; c++) begin
         apb(1, acmd_pkg::CTRL_OFS, c);
         proc.cyc(0, 12'h100, 4'h0, 8'h00);
         chk("low", (c < 3) ? 2 : 1, store_sel.prog);
         proc.cyc(0, 12'h800, 4'h0, 8'h00);
         chk("high", hi_tab[c % 3], store_sel.prog);
         proc.cyc(1, 12'h005, 4'h4, 8'h00);
         chk("page", dt_tab[c % 3], store_sel.data);
         proc.idle();
      end
      apb(1, acmd_pkg::CTRL_OFS, 32'h06);
      apb(0, acmd_pkg::CTRL_OFS, 0);
      chk("keep", 32'h05, rd);
      // The code limit follows the upgrade bit already held, so fit it first.
      apb(1, acmd_pkg::CTRL_OFS, 32'h20);
      apb(1, acmd_pkg::CTRL_OFS, 32'h26);
      apb(0, acmd_pkg::CTRL_OFS, 0);
      chk("upg", 32'h26, rd);
      proc.cyc(0, 12'h100, 4'h0, 8'h00);
      chk("upg_low", acmd_pkg::ST_PRAM, store_sel.prog);
      apb(1, acmd_pkg::CTRL_OFS, 32'h00);
      proc.cyc(0, 12'h3F0, 4'h0, 8'h00);
      chk("pram", 9'h1A5, {bus_oe, bus_out});
      proc.cyc(1, 12'h005, 4'h0, 8'h00);
      chk("udata", 9'h13C, {bus_oe, bus_out});
      // Let the read drive drop before the processor drives its byte.
      proc.idle();
      proc.cyc(2, 12'h006, 4'h0, 8'h5A);
      proc.cyc(1, 12'h006, 4'h2, 8'h00);
      chk("page2", acmd_pkg::ST_NONE, store_sel.data);
      proc.idle();
      apb(0, acmd_pkg::STATUS_OFS, 0);
      chk("reentry", 32'h40, rd & 32'h40);
      apb(1, acmd_pkg::MEM_ADDR_OFS, 32'h006);
      apb(0, acmd_pkg::UDATA_OFS, 0);
      chk("uwrite", 32'h5A, rd);
      apb(1, acmd_pkg::MEM_ADDR_OFS, 32'h006);
      apb(0, acmd_pkg::SCRATCH_OFS, 0);
      chk("apart", 32'h77, rd);
      end_of_test();
   end
endmodule
